// >>> verilog/boot_mode_pkg.sv
// boot source straps, mode encoding and reset values for the boot mode selector
// Notes on behaviour
// - EPROM select high with link select low means 8-bit EPROM boot
// - EPROM select low: link and memory straps decide
// - link select high with memory pin high means link port boot; with memory pin low it is reserved
// - link select low: host boot or none
// - EPROM-only straps turn memory pin into chip select
// - only the bus master drives the pin
// - memory pin strapped low with both selects low: run from external memory
// - pin is driven only in EPROM boot mode
// - pattern 001 is host, 011 is link
// - 000 is no boot; 010, 11x reserved
package boot_mode_pkg;

  // clock rate of the processor clock
  localparam int CLK_FREQ_HZ = 20000000;

  // byte width of the boot EPROM image
  localparam int EPROM_DATA_WIDTH = 8;

  // the three straps, as sampled
  typedef struct packed {
    logic eprom_boot_select; // high: boot from EPROM
    logic link_boot_select; // high: boot through a link port
    logic boot_memory_select_pin; // memory select pin read as an input
  } strap_type;

  // decoded boot source; reserved marks an illegal strap pattern
  typedef enum logic [2:0] {
    BOOT_FROM_EPROM,
    BOOT_FROM_HOST,
    BOOT_FROM_LINK,
    BOOT_NONE,
    BOOT_RESERVED
  } boot_mode_type;

  // one flag per source, for logic that wants plain levels
  typedef struct packed {
    logic eprom; // EPROM loader to run
    logic host; // wait for the host to load
    logic link; // wait for a link port to load
    logic external_fetch; // no loader, fetch from external memory
    logic reserved; // strap pattern not allowed
  } boot_flags_type;

  // values after reset
  localparam strap_type STRAP_RESET = 3'h0;
  localparam boot_mode_type MODE_RESET = BOOT_NONE;
  localparam boot_flags_type FLAGS_RESET = 5'h00;
  localparam logic PIN_OUT_RESET = 1'h1;
  localparam logic PIN_OE_N_RESET = 1'h1;

  // strap decode, order is EPROM select, link select, memory select
  function automatic boot_mode_type decode_straps(input strap_type s);
    boot_mode_type m;
    m = BOOT_RESERVED;
    if (s.eprom_boot_select)
    begin
      // with EPROM select high the pin is not read; it is an output only in EPROM mode
      m = s.link_boot_select ? BOOT_RESERVED : BOOT_FROM_EPROM;
    end
    else
    begin
      case ({s.link_boot_select, s.boot_memory_select_pin})
        2'h0: m = BOOT_NONE;
        2'h1: m = BOOT_FROM_HOST;
        2'h3: m = BOOT_FROM_LINK;
        default: m = BOOT_RESERVED;
      endcase
    end
    return m;
  endfunction

  // expand a mode into its flag set
  function automatic boot_flags_type mode_flags(input boot_mode_type m);
    boot_flags_type f;
    f = FLAGS_RESET;
    case (m)
      BOOT_FROM_EPROM: f.eprom = 1'h1;
      BOOT_FROM_HOST: f.host = 1'h1;
      BOOT_FROM_LINK: f.link = 1'h1;
      BOOT_NONE: f.external_fetch = 1'h1;
      default: f.reserved = 1'h1;
    endcase
    return f;
  endfunction

endpackage

// >>> verilog/strap_latch.sv
// strap sampling register, open during reset and frozen after it
`timescale 1ns/100ps
module strap_latch
(
  input wire logic clk,
  input wire logic srst,
  input wire boot_mode_pkg::strap_type straps_in,
  output boot_mode_pkg::strap_type straps_q
);

  // follow the pins while reset stands, then hold until the next reset;
  // board straps are fixed, so the last reset cycle is as good as any
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      straps_q <= straps_in;
    end
  end

endmodule

// >>> verilog/boot_mode_select.sv
// boot source decoder and boot memory select pin control
`timescale 1ns/100ps
module boot_mode_select
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic EPROM_BOOT_SELECT,
  input wire logic LINK_BOOT_SELECT,
  input wire logic BOOT_MEMORY_SELECT_PIN_I,
  output logic BOOT_MEMORY_SELECT_PIN_O,
  output logic BOOT_MEMORY_SELECT_PIN_OE_N,
  input wire logic BUS_MASTER,
  input wire logic EPROM_CS_REQ,
  output boot_mode_pkg::boot_mode_type BOOT_MODE,
  output boot_mode_pkg::boot_flags_type BOOT_FLAGS
);

  // the three straps gathered for the latch
  boot_mode_pkg::strap_type straps_in;
  // straps as caught at reset
  boot_mode_pkg::strap_type straps_q;
  // decode of the caught straps
  boot_mode_pkg::boot_mode_type mode_d;
  // registered mode
  boot_mode_pkg::boot_mode_type mode_q;
  // registered flag set
  boot_mode_pkg::boot_flags_type flags_q;
  // pin drive level, low selects the EPROM
  logic pin_out_q;
  logic pin_out_d;
  // pin enable, low while driving
  logic pin_oe_n_q;
  logic pin_oe_n_d;

  // pack the strap pins
  always_comb
  begin
    straps_in.eprom_boot_select = EPROM_BOOT_SELECT;
    straps_in.link_boot_select = LINK_BOOT_SELECT;
    straps_in.boot_memory_select_pin = BOOT_MEMORY_SELECT_PIN_I;
  end

  // strap capture register
  strap_latch u_strap_latch
  (
    .clk(CLK),
    .srst(SRST),
    .straps_in(straps_in),
    .straps_q(straps_q)
  );

  // decode runs on the frozen straps, never on the live pins
  always_comb
  begin
    mode_d = boot_mode_pkg::decode_straps(straps_q);
  end

  // mode register; reloads each cycle but its source is frozen
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mode_q <= boot_mode_pkg::MODE_RESET;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // flag register, in step with the mode
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      flags_q <= boot_mode_pkg::FLAGS_RESET;
    end
    else
    begin
      flags_q <= boot_mode_pkg::mode_flags(mode_d);
    end
  end

  // pin enable: drive only in EPROM mode and only as bus master;
  // in every other mode the pin is an input, so it is never driven
  always_comb
  begin
    if (mode_q == boot_mode_pkg::BOOT_FROM_EPROM && BUS_MASTER)
    begin
      pin_oe_n_d = 1'h0;
    end
    else
    begin
      pin_oe_n_d = 1'h1;
    end
  end

  // pin level: chip select follows the loader's request when driving
  always_comb
  begin
    if (mode_q == boot_mode_pkg::BOOT_FROM_EPROM && BUS_MASTER)
    begin
      pin_out_d = ~EPROM_CS_REQ;
    end
    else
    begin
      pin_out_d = boot_mode_pkg::PIN_OUT_RESET;
    end
  end

  // pin registers; reset keeps the pin released so the strap can be read
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_oe_n_q <= boot_mode_pkg::PIN_OE_N_RESET;
      pin_out_q <= boot_mode_pkg::PIN_OUT_RESET;
    end
    else
    begin
      pin_oe_n_q <= pin_oe_n_d;
      pin_out_q <= pin_out_d;
    end
  end

  // outputs
  assign BOOT_MODE = mode_q;
  assign BOOT_FLAGS = flags_q;
  assign BOOT_MEMORY_SELECT_PIN_O = pin_out_q;
  assign BOOT_MEMORY_SELECT_PIN_OE_N = pin_oe_n_q;

  // first cycle out of reset
  sequence s_released;
    $fell(SRST);
  endsequence

  // driving as master in EPROM mode
  sequence s_eprom_master;
    mode_q == boot_mode_pkg::BOOT_FROM_EPROM && BUS_MASTER;
  endsequence

  // EPROM straps give EPROM mode
  a_eprom_mode_pick: assert property (@(posedge CLK) disable iff (SRST)
    s_released ##0 ($past(EPROM_BOOT_SELECT) && !$past(LINK_BOOT_SELECT))
    |=> BOOT_MODE == boot_mode_pkg::BOOT_FROM_EPROM && BOOT_FLAGS.eprom)
    else $error("EPROM straps did not select EPROM boot");

  // pattern 001 gives host boot
  a_host_mode_pick: assert property (@(posedge CLK) disable iff (SRST)
    s_released ##0 ($past(straps_in) == 3'h1)
    |=> BOOT_MODE == boot_mode_pkg::BOOT_FROM_HOST && BOOT_FLAGS.host)
    else $error("pattern 001 did not select host boot");

  // pattern 011 gives link boot
  a_link_mode_pick: assert property (@(posedge CLK) disable iff (SRST)
    s_released ##0 ($past(straps_in) == 3'h3)
    |=> BOOT_MODE == boot_mode_pkg::BOOT_FROM_LINK && BOOT_FLAGS.link)
    else $error("pattern 011 did not select link boot");

  // pattern 000 runs from external memory
  a_no_boot_pick: assert property (@(posedge CLK) disable iff (SRST)
    s_released ##0 ($past(straps_in) == 3'h0)
    |=> BOOT_MODE == boot_mode_pkg::BOOT_NONE && BOOT_FLAGS.external_fetch)
    else $error("pattern 000 did not select external fetch");

  // reserved patterns are flagged
  a_reserved_flag: assert property (@(posedge CLK) disable iff (SRST)
    s_released ##0 ($past(straps_in) == 3'h2 || $past(straps_in) >= 3'h6)
    |=> BOOT_MODE == boot_mode_pkg::BOOT_RESERVED && BOOT_FLAGS.reserved)
    else $error("reserved strap pattern not flagged");

  // mode frozen once settled, whatever the pins do
  a_mode_held: assert property (@(posedge CLK) disable iff (SRST)
    !$past(SRST) && !$past(SRST, 2) |-> $stable(BOOT_MODE) && $stable(BOOT_FLAGS))
    else $error("boot mode changed outside reset");

  // master in EPROM mode drives the pin next cycle
  a_pin_drive_master: assert property (@(posedge CLK) disable iff (SRST)
    s_eprom_master |=> !BOOT_MEMORY_SELECT_PIN_OE_N)
    else $error("bus master in EPROM mode not driving the pin");

  // a non-master never drives
  a_pin_slave_off: assert property (@(posedge CLK) disable iff (SRST)
    !BUS_MASTER |=> BOOT_MEMORY_SELECT_PIN_OE_N)
    else $error("pin driven without bus mastership");

  // outside EPROM mode the pin stays an input
  a_pin_input_mode: assert property (@(posedge CLK) disable iff (SRST)
    BOOT_MODE != boot_mode_pkg::BOOT_FROM_EPROM |=> BOOT_MEMORY_SELECT_PIN_OE_N)
    else $error("pin driven outside EPROM boot mode");

  // chip select tracks the loader request, active low
  a_cs_follow: assert property (@(posedge CLK) disable iff (SRST)
    s_eprom_master ##0 EPROM_CS_REQ |=> !BOOT_MEMORY_SELECT_PIN_O)
    else $error("chip select did not follow the request");

  // chip select lifts once the request, the mode or mastership goes away
  a_cs_idle: assert property (@(posedge CLK) disable iff (SRST)
    !(mode_q == boot_mode_pkg::BOOT_FROM_EPROM && BUS_MASTER && EPROM_CS_REQ)
      |=> BOOT_MEMORY_SELECT_PIN_O)
    else $error("chip select low without a request");

endmodule

// >>> bench/strap_board.sv
// board side model: wired straps and the resolved boot memory select wire
`timescale 1ns/100ps
module strap_board
(
  input wire boot_mode_pkg::strap_type straps, // levels the board is wired to
  input wire logic pin_o, // device drive level
  input wire logic pin_oe_n, // low while the device drives
  output logic eprom_sel, // strap wire
  output logic link_sel, // strap wire
  output logic pin_wire // resolved pin level
);
  // straps are plain wired levels, never driven by logic
  assign eprom_sel = straps.eprom_boot_select;
  assign link_sel = straps.link_boot_select;
  // board resistor sets the level whenever the device lets go
  assign pin_wire = pin_oe_n ? straps.boot_memory_select_pin : pin_o;
endmodule

// >>> bench/boot_mode_select_tb_top.sv
// randomised self-checking bench for the boot mode selector
`timescale 1ns/100ps
module boot_mode_select_tb_top;
  logic clk = 1'h0; // 20 MHz clock
  logic srst = 1'h1; // synchronous reset
  logic bus_master = 1'h0; // mastership level
  logic cs_req = 1'h0; // loader select request
  logic pbm; // mastership held before the last edge
  logic pcs; // request held before the last edge
  logic pin_o, oe_n, eprom_sel, link_sel, pin_wire; // pin and strap wires
  boot_mode_pkg::strap_type straps = 3'h0; // board levels
  boot_mode_pkg::boot_mode_type mode; // decoded source
  boot_mode_pkg::boot_flags_type flags; // decoded flags
  int err_count = 0; // mismatches
  int samples_checked = 0; // comparisons

  // clock generator
  initial
  begin
    forever #25 clk = ~clk;
  end

  boot_mode_select dut
  (
    .CLK(clk), .SRST(srst), .EPROM_BOOT_SELECT(eprom_sel), .LINK_BOOT_SELECT(link_sel),
    .BOOT_MEMORY_SELECT_PIN_I(pin_wire), .BOOT_MEMORY_SELECT_PIN_O(pin_o),
    .BOOT_MEMORY_SELECT_PIN_OE_N(oe_n), .BUS_MASTER(bus_master), .EPROM_CS_REQ(cs_req),
    .BOOT_MODE(mode), .BOOT_FLAGS(flags)
  );

  strap_board board
  (
    .straps(straps), .pin_o(pin_o), .pin_oe_n(oe_n),
    .eprom_sel(eprom_sel), .link_sel(link_sel), .pin_wire(pin_wire)
  );

  // expected source from the strap pattern
  function automatic boot_mode_pkg::boot_mode_type exp_mode(input boot_mode_pkg::strap_type s);
    if (s.eprom_boot_select)
      return s.link_boot_select ? boot_mode_pkg::BOOT_RESERVED : boot_mode_pkg::BOOT_FROM_EPROM;
    if (s.link_boot_select)
      return s.boot_memory_select_pin ? boot_mode_pkg::BOOT_FROM_LINK : boot_mode_pkg::BOOT_RESERVED;
    return s.boot_memory_select_pin ? boot_mode_pkg::BOOT_FROM_HOST : boot_mode_pkg::BOOT_NONE;
  endfunction

  // expected one-hot flags, msb eprom down to reserved
  function automatic boot_mode_pkg::boot_flags_type exp_flags(input boot_mode_pkg::boot_mode_type m);
    case (m)
      boot_mode_pkg::BOOT_FROM_EPROM: return 5'h10;
      boot_mode_pkg::BOOT_FROM_HOST: return 5'h08;
      boot_mode_pkg::BOOT_FROM_LINK: return 5'h04;
      boot_mode_pkg::BOOT_NONE: return 5'h02;
      default: return 5'h01;
    endcase
  endfunction

  // verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic cmp_mode(input string n, input boot_mode_pkg::boot_mode_type e,
                          input boot_mode_pkg::boot_mode_type g);
    cmp_bit({n, " b0"}, e[0], g[0]);
    cmp_bit({n, " b1"}, e[1], g[1]);
    cmp_bit({n, " b2"}, e[2], g[2]);
  endtask

  task automatic cmp_flags(input boot_mode_pkg::boot_flags_type e,
                           input boot_mode_pkg::boot_flags_type g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD flags exp %0h got %0h", e, g);
    end
  endtask

  // one reset with a strap pattern, then random pin traffic
  task automatic run_mode(input boot_mode_pkg::strap_type s);
    boot_mode_pkg::boot_mode_type m;
    logic ep;
    m = exp_mode(s);
    ep = (m == boot_mode_pkg::BOOT_FROM_EPROM);
    @(posedge clk);
    srst <= 1'h1;
    straps <= s;
    repeat (6) @(posedge clk);
    #1;
    cmp_bit("oe_n in reset", 1'h1, oe_n);
    cmp_bit("pin_o in reset", 1'h1, pin_o);
    cmp_mode("mode in reset", boot_mode_pkg::BOOT_NONE, mode);
    cmp_flags(5'h00, flags);
    @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    // straps turned round after release must be ignored
    straps <= ~s;
    bus_master <= 1'($urandom);
    cs_req <= 1'($urandom);
    repeat (24)
    begin
      @(posedge clk);
      pbm = bus_master;
      pcs = cs_req;
      bus_master <= 1'($urandom);
      cs_req <= 1'($urandom);
      #1;
      cmp_bit("oe_n", !(ep && pbm), oe_n);
      cmp_bit("pin_o", !(ep && pbm && pcs), pin_o);
      cmp_mode("mode", m, mode);
    end
    cmp_flags(exp_flags(m), flags);
  endtask

  // main sequence: every pattern, then a few random ones
  initial
  begin
    void'($urandom(32'hA44B));
    for (int i = 0; i < 8; i++)
      run_mode(3'(i));
    repeat (4) run_mode(3'($urandom));
    stop_test();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
